// ==== inc/bfo_pkg.sv ====
// Package for the bit and flag operations unit: opcodes, status bit positions,
// register offsets, reset values, controller states and shared helpers.
// Assumes the core decoder presents one operation at a time with these codes.
package bfo_pkg;

  localparam int OP_W = 5;
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int IOA_W = 6;
  localparam int RIDX_W = 5;
  localparam int RADDR_W = 2;

  localparam logic [OP_W-1:0] OP_NONE = 5'h00;
  localparam logic [OP_W-1:0] OP_BRANCH_OVERFLOW_CLEAR = 5'h01;
  localparam logic [OP_W-1:0] OP_BRANCH_IRQ_ENABLED = 5'h02;
  localparam logic [OP_W-1:0] OP_BRANCH_IRQ_DISABLED = 5'h03;
  localparam logic [OP_W-1:0] OP_IO_BIT_SET = 5'h04;
  localparam logic [OP_W-1:0] OP_IO_BIT_CLEAR = 5'h05;
  localparam logic [OP_W-1:0] OP_LOGICAL_LEFT_SHIFT = 5'h06;
  localparam logic [OP_W-1:0] OP_LOGICAL_RIGHT_SHIFT = 5'h07;
  localparam logic [OP_W-1:0] OP_ROTATE_LEFT_CARRY = 5'h08;
  localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_CARRY = 5'h09;
  localparam logic [OP_W-1:0] OP_ARITH_RIGHT_SHIFT = 5'h0a;
  localparam logic [OP_W-1:0] OP_NIBBLE_SWAP = 5'h0b;
  localparam logic [OP_W-1:0] OP_STATUS_FLAG_SET = 5'h0c;
  localparam logic [OP_W-1:0] OP_STATUS_FLAG_CLEAR = 5'h0d;
  localparam logic [OP_W-1:0] OP_BIT_TO_TFLAG = 5'h0e;
  localparam logic [OP_W-1:0] OP_TFLAG_TO_BIT = 5'h0f;
  localparam logic [OP_W-1:0] OP_CARRY_SET = 5'h10;
  localparam logic [OP_W-1:0] OP_CARRY_CLEAR = 5'h11;
  localparam logic [OP_W-1:0] OP_NEGATIVE_SET = 5'h12;
  localparam logic [OP_W-1:0] OP_NEGATIVE_CLEAR = 5'h13;
  localparam logic [OP_W-1:0] OP_ZERO_FLAG_SET = 5'h14;
  localparam logic [OP_W-1:0] OP_ZERO_FLAG_CLEAR = 5'h15;
  localparam logic [OP_W-1:0] OP_GLOBAL_IRQ_ON = 5'h16;
  localparam logic [OP_W-1:0] OP_GLOBAL_IRQ_OFF = 5'h17;
  localparam logic [OP_W-1:0] OP_SIGN_FLAG_SET = 5'h18;
  localparam logic [OP_W-1:0] OP_SIGN_FLAG_CLEAR = 5'h19;
  localparam logic [OP_W-1:0] OP_OVERFLOW_SET = 5'h1a;
  localparam logic [OP_W-1:0] OP_OVERFLOW_CLEAR = 5'h1b;
  localparam logic [OP_W-1:0] OP_TRANSFER_FLAG_SET = 5'h1c;
  localparam logic [OP_W-1:0] OP_TRANSFER_FLAG_CLEAR = 5'h1d;
  localparam logic [OP_W-1:0] OP_HALF_CARRY_SET = 5'h1e;
  localparam logic [OP_W-1:0] OP_HALF_CARRY_CLEAR = 5'h1f;

  localparam logic [2:0] SB_C = 3'h0;
  localparam logic [2:0] SB_Z = 3'h1;
  localparam logic [2:0] SB_N = 3'h2;
  localparam logic [2:0] SB_V = 3'h3;
  localparam logic [2:0] SB_S = 3'h4;
  localparam logic [2:0] SB_H = 3'h5;
  localparam logic [2:0] SB_T = 3'h6;
  localparam logic [2:0] SB_I = 3'h7;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [RADDR_W-1:0] REG_STATUS = 2'h0;
  localparam logic [RADDR_W-1:0] REG_RESULT = 2'h1;
  localparam logic [RADDR_W-1:0] REG_STATE = 2'h2;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BRANCH = 4'h2,
    ST_IO_RD = 4'h4,
    ST_IO_WR = 4'h8
  } bfo_state_t;

  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // Dedicated set and clear codes come in pairs; the low code bit picks clear.
  function automatic logic [2:0] fixed_flag_index(input logic [OP_W-1:0] code);
    case (code[3:1])
      3'h0: fixed_flag_index = SB_C;
      3'h1: fixed_flag_index = SB_N;
      3'h2: fixed_flag_index = SB_Z;
      3'h3: fixed_flag_index = SB_I;
      3'h4: fixed_flag_index = SB_S;
      3'h5: fixed_flag_index = SB_V;
      3'h6: fixed_flag_index = SB_T;
      default: fixed_flag_index = SB_H;
    endcase
  endfunction

endpackage

// ==== rtl/bfo_shift.sv ====
// Combinational shifter for shifts, rotates through carry and nibble swap.
// Assumes the caller supplies the current carry and registers the outputs.
`timescale 1ns/100ps
module bfo_shift (
  input wire logic [bfo_pkg::OP_W-1:0] op_code,
  input wire logic [bfo_pkg::DATA_W-1:0] data_in,
  input wire logic carry_in,
  output logic [bfo_pkg::DATA_W-1:0] result,
  output logic hit,
  output logic flag_upd,
  output logic flag_z,
  output logic flag_c,
  output logic flag_n,
  output logic flag_v
);
  import bfo_pkg::*;

  always_comb begin
    result = data_in;
    flag_c = carry_in;
    hit = 1'b1;
    flag_upd = 1'b1;
    case (op_code)
      OP_LOGICAL_LEFT_SHIFT: begin
        result = {data_in[6:0], 1'b0};
        flag_c = data_in[7];
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        result = {1'b0, data_in[7:1]};
        flag_c = data_in[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        result = {data_in[6:0], carry_in};
        flag_c = data_in[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        result = {carry_in, data_in[7:1]};
        flag_c = data_in[0];
      end
      OP_ARITH_RIGHT_SHIFT: begin
        result = {data_in[7], data_in[7:1]};
        flag_c = data_in[0];
      end
      OP_NIBBLE_SWAP: begin
        result = {data_in[3:0], data_in[7:4]};
        flag_upd = 1'b0;
      end
      default: begin
        hit = 1'b0;
        flag_upd = 1'b0;
      end
    endcase
  end

  // Overflow is N xor C after the shift so that signed tests after a shift work.
  assign flag_z = (result == 8'h00);
  assign flag_n = result[7];
  assign flag_v = flag_n ^ flag_c;

endmodule // bfo_shift

// ==== rtl/bfo_unit.sv ====
// Bit and flag operations unit: branches on V and I, I/O bit set and clear,
// shifts and rotates, nibble swap, T transfers and status flag set and clear.
// Assumes the core hands over one operation at a time and returns I/O read
// data combinationally in the same cycle as the I/O read strobe.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
// Function
// - Branch if overflow clear loads PC plus offset plus one; flags kept.
// - Branch if interrupts enabled adds offset plus one to PC; flags kept.
// - Branch if interrupts disabled adds offset plus one to PC; flags kept.
// - I/O bit set forces selected bit to one in two cycles, flags kept.
// - I/O bit clear forces selected bit to zero in two cycles, flags kept.
// - Logical shifts insert zero and update Z, C, N, V in one cycle.
// - Rotate left: old carry to bit 0, old bit 7 to carry.
// - Rotate right: old carry to bit 7, old bit 0 to carry.
// - Bit store copies chosen source bit into T, nothing else changes.
// - Bit load writes T into chosen destination bit, flags unchanged.
// - Dedicated single-cycle forms set or clear only the sign flag.
// - Dedicated single-cycle forms set or clear only the overflow flag.
// - Dedicated single-cycle forms set or clear only the half carry flag.
module bfo_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [bfo_pkg::OP_W-1:0] op_code,
  input wire logic [2:0] op_bit,
  input wire logic [bfo_pkg::RIDX_W-1:0] op_dst,
  input wire logic [bfo_pkg::DATA_W-1:0] op_data,
  input wire logic [bfo_pkg::OFS_W-1:0] op_offset,
  input wire logic [bfo_pkg::IOA_W-1:0] op_io_addr,
  input wire logic [bfo_pkg::PC_W-1:0] pc_cur,
  output logic op_ready,
  output logic op_done,
  output logic rf_we,
  output logic [bfo_pkg::RIDX_W-1:0] rf_waddr,
  output logic [bfo_pkg::DATA_W-1:0] rf_wdata,
  output logic pc_we,
  output logic [bfo_pkg::PC_W-1:0] pc_value,
  output logic io_rd,
  output logic io_wr,
  output logic [bfo_pkg::IOA_W-1:0] io_addr,
  output logic [bfo_pkg::DATA_W-1:0] io_wdata,
  input wire logic [bfo_pkg::DATA_W-1:0] io_rdata,
  output logic [bfo_pkg::DATA_W-1:0] status,
  input wire logic [bfo_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [bfo_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bfo_pkg::DATA_W-1:0] reg_rdata
);
  import bfo_pkg::*;

  bfo_state_t state;
  bfo_state_t next_state;
  logic [DATA_W-1:0] next_status;
  logic [DATA_W-1:0] io_mask;
  logic io_set_op;

  wire logic accept;
  wire logic is_boc;
  wire logic is_bie;
  wire logic is_bid;
  wire logic take;
  wire logic is_io;
  wire logic is_tstore;
  wire logic is_tload;
  wire logic is_gen;
  wire logic is_fixed;
  wire logic bit_pick;
  wire logic [DATA_W-1:0] tload_val;
  wire logic [PC_W-1:0] branch_target;
  wire logic [DATA_W-1:0] sh_result;
  wire logic sh_hit;
  wire logic sh_upd;
  wire logic sh_z;
  wire logic sh_c;
  wire logic sh_n;
  wire logic sh_v;
  wire logic [DATA_W-1:0] sh_mask;
  wire logic [DATA_W-1:0] sh_val;
  wire logic [DATA_W-1:0] flag_mask;
  wire logic [DATA_W-1:0] flag_val;
  wire logic [DATA_W-1:0] status_base;
  wire logic [DATA_W-1:0] io_modified;
  wire logic [DATA_W-1:0] rd_mux;

  // A taken branch or an I/O access holds off the next operation for a cycle.
  assign op_ready = (state == ST_IDLE) || (state == ST_IO_WR);
  assign accept = op_valid && op_ready;

  assign is_boc = (op_code == OP_BRANCH_OVERFLOW_CLEAR);
  assign is_bie = (op_code == OP_BRANCH_IRQ_ENABLED);
  assign is_bid = (op_code == OP_BRANCH_IRQ_DISABLED);
  assign take = (is_boc && !status[SB_V])
              || (is_bie && status[SB_I])
              || (is_bid && !status[SB_I]);
  assign branch_target = pc_cur + {{(PC_W-OFS_W){op_offset[OFS_W-1]}}, op_offset} + PC_STEP;

  assign is_io = (op_code == OP_IO_BIT_SET) || (op_code == OP_IO_BIT_CLEAR);
  assign is_tstore = (op_code == OP_BIT_TO_TFLAG);
  assign is_tload = (op_code == OP_TFLAG_TO_BIT);
  assign is_gen = (op_code == OP_STATUS_FLAG_SET) || (op_code == OP_STATUS_FLAG_CLEAR);
  assign is_fixed = op_code[4];

  assign bit_pick = op_data[op_bit];
  assign tload_val = status[SB_T] ? (op_data | bit_mask(op_bit))
                                : (op_data & ~bit_mask(op_bit));

  bfo_shift u_shift (
    .op_code(op_code),
    .data_in(op_data),
    .carry_in(status[SB_C]),
    .result(sh_result),
    .hit(sh_hit),
    .flag_upd(sh_upd),
    .flag_z(sh_z),
    .flag_c(sh_c),
    .flag_n(sh_n),
    .flag_v(sh_v)
  );

  // Shifts touch Z, C, N and V only; S is left for the arithmetic path.
  assign sh_mask = bit_mask(SB_Z) | bit_mask(SB_C) | bit_mask(SB_N) | bit_mask(SB_V);
  assign sh_val = ({8{sh_z}} & bit_mask(SB_Z)) | ({8{sh_c}} & bit_mask(SB_C))
                | ({8{sh_n}} & bit_mask(SB_N)) | ({8{sh_v}} & bit_mask(SB_V));

  // Each operation names the status bits it owns; all others pass through.
  assign flag_mask = sh_upd ? sh_mask
                   : is_tstore ? bit_mask(SB_T)
                   : is_gen ? bit_mask(op_bit)
                   : is_fixed ? bit_mask(fixed_flag_index(op_code))
                   : 8'h00;
  assign flag_val = sh_upd ? sh_val
                  : is_tstore ? {8{bit_pick}}
                  : is_gen ? {8{op_code == OP_STATUS_FLAG_SET}}
                  : {8{~op_code[0]}};

  // A software write lands first, so an operation in the same cycle still wins.
  assign status_base = (reg_wr && (reg_addr == REG_STATUS)) ? reg_wdata : status;
  assign next_status = accept ? ((status_base & ~flag_mask) | (flag_val & flag_mask))
                              : status_base;

  assign io_modified = io_set_op ? (io_rdata | io_mask)
                                 : (io_rdata & ~io_mask);

  assign rd_mux = (reg_addr == REG_STATUS) ? status
                : (reg_addr == REG_RESULT) ? rf_wdata
                : (reg_addr == REG_STATE) ? {4'h0, state}
                : 8'h00;

  always_comb begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE, ST_IO_WR: begin
        if (accept && take) begin
          next_state = ST_BRANCH;
        end else if (accept && is_io) begin
          next_state = ST_IO_RD;
        end
      end
      ST_BRANCH: next_state = ST_IDLE;
      ST_IO_RD: next_state = ST_IO_WR;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      status <= STATUS_RST;
    end else begin
      state <= next_state;
      status <= next_status;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_waddr <= 5'h00;
      rf_wdata <= 8'h00;
      pc_we <= 1'b0;
      pc_value <= 16'h0000;
      op_done <= 1'b0;
    end else begin
      rf_we <= accept && (sh_hit || is_tload);
      pc_we <= accept && take;
      op_done <= (accept && !is_io) || (state == ST_IO_RD);
      if (accept && (sh_hit || is_tload)) begin
        rf_waddr <= op_dst;
        rf_wdata <= is_tload ? tload_val : sh_result;
      end
      if (accept && take) begin
        pc_value <= branch_target;
      end
    end
  end

  // Read-modify-write: read strobe in the first cycle, write in the second.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      io_addr <= 6'h00;
      io_wdata <= 8'h00;
      io_mask <= 8'h00;
      io_set_op <= 1'b0;
    end else begin
      io_rd <= accept && is_io;
      io_wr <= (state == ST_IO_RD);
      if (accept && is_io) begin
        io_addr <= op_io_addr;
        io_mask <= bit_mask(op_bit);
        io_set_op <= (op_code == OP_IO_BIT_SET);
      end
      if (state == ST_IO_RD) begin
        io_wdata <= io_modified;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Helper terms for the checks below.
  wire logic [DATA_W-1:0] shl_ref = {op_data[6:0], 1'b0};
  wire logic [DATA_W-1:0] shr_ref = {1'b0, op_data[7:1]};
  wire logic [DATA_W-1:0] rotl_ref = {op_data[6:0], status[SB_C]};
  wire logic [DATA_W-1:0] rotr_ref = {status[SB_C], op_data[7:1]};
  wire logic [DATA_W-1:0] sar_ref = {op_data[7], op_data[7:1]};
  wire logic [DATA_W-1:0] swap_ref = {op_data[3:0], op_data[7:4]};
  wire logic [DATA_W-1:0] keep_t_ref = status & ~bit_mask(SB_T);
  wire logic quiet = !reg_wr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ovf_clear_taken: assert property (
    accept && is_boc && !status[SB_V] && quiet |=>
      pc_we && (pc_value == $past(branch_target)) && !op_ready
      && (status == $past(status)) ##1 op_ready)
    else $error("overflow clear branch not taken correctly");

  a_ovf_clear_skip: assert property (
    accept && is_boc && status[SB_V] |=> !pc_we && op_ready && op_done)
    else $error("overflow clear branch taken while V set");

  a_irq_en_branch: assert property (
    accept && is_bie && quiet |=> (pc_we == $past(status[SB_I]))
      && (status == $past(status)))
    else $error("interrupt enabled branch wrong");

  a_irq_dis_branch: assert property (
    accept && is_bid && quiet |=> (pc_we == !$past(status[SB_I]))
      && (status == $past(status)))
    else $error("interrupt disabled branch wrong");

  a_io_set_seq: assert property (
    accept && (op_code == OP_IO_BIT_SET) && quiet |=>
      io_rd && !io_wr ##1 io_wr && !io_rd && ((io_wdata & io_mask) == io_mask)
      && (status == $past(status, 2)) && op_done)
    else $error("I/O bit set sequence wrong");

  a_io_clear_seq: assert property (
    accept && (op_code == OP_IO_BIT_CLEAR) |=>
      io_rd ##1 io_wr && ((io_wdata & io_mask) == 8'h00))
    else $error("I/O bit clear sequence wrong");

  a_shl_result: assert property (
    accept && (op_code == OP_LOGICAL_LEFT_SHIFT) && quiet |=>
      rf_we && (rf_wdata == $past(shl_ref)) && (status[SB_Z] == (rf_wdata == 8'h00))
      && (status[SB_N] == rf_wdata[7]) && (status[SB_V] == (status[SB_N] ^ status[SB_C])))
    else $error("logical left shift wrong");

  a_shr_result: assert property (
    accept && (op_code == OP_LOGICAL_RIGHT_SHIFT) && quiet |=>
      (rf_wdata == $past(shr_ref)) && (status[SB_C] == $past(op_data[0])) && !status[SB_N])
    else $error("logical right shift wrong");

  a_rotl_result: assert property (
    accept && (op_code == OP_ROTATE_LEFT_CARRY) && quiet |=>
      (rf_wdata == $past(rotl_ref)) && (status[SB_C] == $past(op_data[7])))
    else $error("rotate left through carry wrong");

  a_rotr_result: assert property (
    accept && (op_code == OP_ROTATE_RIGHT_CARRY) && quiet |=>
      (rf_wdata == $past(rotr_ref)) && (status[SB_C] == $past(op_data[0])))
    else $error("rotate right through carry wrong");

  a_tflag_store: assert property (
    accept && is_tstore && quiet |=> (status[SB_T] == $past(bit_pick))
      && ((status & ~bit_mask(SB_T)) == $past(keep_t_ref)) && !rf_we)
    else $error("bit store to T wrong");

  a_tflag_load: assert property (
    accept && is_tload && quiet |=> rf_we && (rf_wdata == $past(tload_val))
      && (status == $past(status)))
    else $error("bit load from T wrong");

  a_sign_flag_only: assert property (
    accept && ((op_code == OP_SIGN_FLAG_SET) || (op_code == OP_SIGN_FLAG_CLEAR)) && quiet
      |=> (status[SB_S] == !$past(op_code[0]))
      && ((status ^ $past(status)) & ~bit_mask(SB_S)) == 8'h00)
    else $error("sign flag form touched other bits");

  a_ovf_flag_only: assert property (
    accept && ((op_code == OP_OVERFLOW_SET) || (op_code == OP_OVERFLOW_CLEAR)) && quiet
      |=> (status[SB_V] == !$past(op_code[0]))
      && ((status ^ $past(status)) & ~bit_mask(SB_V)) == 8'h00)
    else $error("overflow flag form touched other bits");

  a_half_flag_only: assert property (
    accept && ((op_code == OP_HALF_CARRY_SET) || (op_code == OP_HALF_CARRY_CLEAR)) && quiet
      |=> (status[SB_H] == !$past(op_code[0]))
      && ((status ^ $past(status)) & ~bit_mask(SB_H)) == 8'h00)
    else $error("half carry form touched other bits");

  a_sar_result: assert property (
    accept && (op_code == OP_ARITH_RIGHT_SHIFT) && quiet |=>
      (rf_wdata == $past(sar_ref)) && (status[SB_C] == $past(op_data[0])))
    else $error("arithmetic right shift wrong");

  a_swap_result: assert property (
    accept && (op_code == OP_NIBBLE_SWAP) && quiet |=>
      rf_we && (rf_wdata == $past(swap_ref)) && (status == $past(status)))
    else $error("nibble swap wrong");

  a_generic_flag: assert property (
    accept && is_gen && quiet |=>
      (((status ^ $past(status)) & ~bit_mask($past(op_bit))) == 8'h00)
      && ((status & bit_mask($past(op_bit))) != 8'h00) == $past(op_code == OP_STATUS_FLAG_SET))
    else $error("generic flag form wrong");

  c_branch_taken: cover property (accept && take ##1 pc_we ##1 op_ready);
  c_io_set: cover property (accept && (op_code == OP_IO_BIT_SET) ##1 io_rd ##1 io_wr);
  c_rotate_chain: cover property (accept && (op_code == OP_ROTATE_LEFT_CARRY)
    ##1 accept && (op_code == OP_ROTATE_LEFT_CARRY));
  c_generic_flag: cover property (accept && is_gen && (op_bit == SB_I));

endmodule // bfo_unit

// ==== verification/bfo_unit_test.sv ====
// Self-checking testbench for the bit and flag operations unit.
// Assumes the unit is alone on its ports; the bench plays decoder, I/O space and software.
`timescale 1ns/100ps
module bfo_unit_test;
  import bfo_pkg::*;
  logic ref_clk = 0, rst = 1, op_valid = 0, reg_wr = 0, reg_rd = 0;
  logic [4:0] op_code = 5'h00, op_dst = 5'h00, dst, opc;
  logic [2:0] op_bit = 3'h0, bsel;
  logic [7:0] op_data = 8'h00, io_rdata = 8'h00, reg_wdata = 8'h00, iod, want, d, res, rd;
  logic [7:0] lastw;
  logic [6:0] op_offset = 7'h00, ofs;
  logic [5:0] op_io_addr = 6'h00, ioa;
  logic [15:0] pc_cur = 16'h0000, pc;
  logic [1:0] reg_addr = 2'h0;
  logic op_ready, op_done, rf_we, pc_we, io_rd, io_wr, cy, cond;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata, io_wdata, status, reg_rdata;
  logic [15:0] pc_value;
  logic [5:0] io_addr;
  logic [2:0] fix [0:7] = '{SB_C, SB_N, SB_Z, SB_I, SB_S, SB_V, SB_T, SB_H};
  integer seed = 28280, err_count = 0, n_checks = 0, cycles = 0, i;
  bfo_unit DUT (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_bit(op_bit), .op_dst(op_dst), .op_data(op_data), .op_offset(op_offset),
    .op_io_addr(op_io_addr), .pc_cur(pc_cur), .op_ready(op_ready), .op_done(op_done),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .pc_we(pc_we),
    .pc_value(pc_value), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .status(status), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  always #5 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The ceiling is about 38 times the cycles that the sequence below needs.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 0;
    if (a == REG_STATUS) want = v;
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  // Offers one operation; it is taken at the second edge and the task returns in cycle c1.
  task automatic run_op(input logic [4:0] c, input logic [2:0] b, input logic [7:0] v,
      input logic [6:0] k);
    @(posedge ref_clk);
    dst = 5'($random(seed));
    ioa = 6'($random(seed));
    pc = 16'($random(seed));
    iod = 8'($random(seed));
    op_valid <= 1;
    op_code <= c;
    op_bit <= b;
    op_data <= v;
    op_offset <= k;
    op_dst <= dst;
    op_io_addr <= ioa;
    pc_cur <= pc;
    io_rdata <= iod;
    @(posedge ref_clk);
    op_valid <= 0;
    #1;
  endtask
  // Returns carry out above the 8-bit result.
  function automatic logic [8:0] shift_exp(input logic [4:0] c, input logic [7:0] v,
      input logic ci);
    case (c)
      OP_LOGICAL_LEFT_SHIFT: shift_exp = {v[7], v[6:0], 1'b0};
      OP_LOGICAL_RIGHT_SHIFT: shift_exp = {v[0], 1'b0, v[7:1]};
      OP_ROTATE_LEFT_CARRY: shift_exp = {v[7], v[6:0], ci};
      OP_ROTATE_RIGHT_CARRY: shift_exp = {v[0], ci, v[7:1]};
      OP_ARITH_RIGHT_SHIFT: shift_exp = {v[0], v[7], v[7:1]};
      default: shift_exp = {ci, v[3:0], v[7:4]};
    endcase
  endfunction
  initial begin
    want = STATUS_RST;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    #1;
    chk("status", {8'h00, STATUS_RST}, status);
    chk("op_ready", 1, op_ready);
    reg_read(REG_STATE, rd);
    chk("state", 8'h01, rd);
    for (i = 0; i < 60; i++) begin
      reg_write(REG_STATUS, 8'($random(seed)));
      d = (i < 6) ? 8'h80 : (i < 12) ? 8'h01 : 8'($random(seed));
      opc = OP_LOGICAL_LEFT_SHIFT + 5'(i % 6);
      {cy, res} = shift_exp(opc, d, want[SB_C]);
      run_op(opc, 3'h0, d, 7'h00);
      if (opc != OP_NIBBLE_SWAP) begin
        want[SB_C] = cy;
        want[SB_Z] = (res == 8'h00);
        want[SB_N] = res[7];
        want[SB_V] = res[7] ^ cy;
      end
      chk("rf_we", 1, rf_we);
      chk("rf_waddr", dst, rf_waddr);
      chk("rf_wdata", res, rf_wdata);
      chk("status", want, status);
      chk("op_done", 1, op_done);
    end
    $display("shift test done");
    for (i = 0; i < 16; i++) begin
      run_op(5'h10 + 5'(i), 3'h0, 8'h00, 7'h00);
      want[fix[i / 2]] = ~i[0];
      chk("status", want, status);
    end
    for (i = 0; i < 16; i++) begin
      run_op(i[0] ? OP_STATUS_FLAG_CLEAR : OP_STATUS_FLAG_SET, 3'(i / 2), 8'h00, 7'h00);
      want[i / 2] = ~i[0];
      chk("status", want, status);
    end
    $display("flag test done");
    for (i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      bsel = 3'($random(seed));
      run_op(OP_BIT_TO_TFLAG, bsel, d, 7'h00);
      want[SB_T] = d[bsel];
      chk("status", want, status);
      d = 8'($random(seed));
      res = d;
      res[bsel] = want[SB_T];
      run_op(OP_TFLAG_TO_BIT, bsel, d, 7'h00);
      chk("rf_wdata", res, rf_wdata);
      chk("status", want, status);
      lastw = res;
    end
    $display("transfer test done");
    for (i = 0; i < 24; i++) begin
      reg_write(REG_STATUS, 8'($random(seed)));
      opc = OP_BRANCH_OVERFLOW_CLEAR + 5'(i % 3);
      ofs = (i < 3) ? 7'h40 : (i < 6) ? 7'h3f : 7'($random(seed));
      cond = (i % 3 == 0) ? !want[SB_V] : (i % 3 == 1) ? want[SB_I] : !want[SB_I];
      run_op(opc, 3'h0, 8'h00, ofs);
      pc = pc + {{9{ofs[6]}}, ofs} + PC_STEP;
      chk("pc_we", cond, pc_we);
      if (cond) chk("pc_value", pc, pc_value);
      chk("op_ready", !cond, op_ready);
      chk("op_done", 1, op_done);
      chk("status", want, status);
    end
    $display("branch test done");
    for (i = 0; i < 16; i++) begin
      bsel = 3'($random(seed));
      run_op(OP_IO_BIT_SET + 5'(i % 2), bsel, 8'h00, 7'h00);
      chk("io_rd", 1, io_rd);
      chk("io_addr", ioa, io_addr);
      chk("op_done", 0, op_done);
      @(posedge ref_clk);
      io_rdata <= ~iod;
      #1;
      res = (i % 2) ? (iod & ~(8'h01 << bsel)) : (iod | (8'h01 << bsel));
      chk("io_wr", 1, io_wr);
      chk("io_wdata", res, io_wdata);
      chk("op_done", 1, op_done);
      chk("status", want, status);
    end
    $display("io test done");
    reg_write(REG_STATUS, 8'($random(seed)));
    reg_read(REG_STATUS, rd);
    chk("status read", want, rd);
    reg_write(REG_RESULT, ~lastw);
    reg_read(REG_RESULT, rd);
    chk("result read", lastw, rd);
    reg_read(2'h3, rd);
    chk("unmapped read", 8'h00, rd);
    $display("register test done");
    finish_test();
  end
endmodule // bfo_unit_test
